// File: sibdec_pkg.sv
// Shared constants and types for the serial interrupt bus status decoder.
package sibdec_pkg;

  // Width of the message cycle counter; 34 cycles fit in six bits.
  localparam int unsigned CYC_W = 6;

  // Message lengths in bus cycles.
  localparam logic [5:0] EOI_LEN    = 6'h0e;  // 14 cycles.
  localparam logic [5:0] SHORT_LEN  = 6'h15;  // 21 cycles.
  localparam logic [5:0] LOWEST_LEN = 6'h22;  // 34 cycles.

  // Status cycle positions within a message.
  localparam logic [5:0] EOI_A_CYC   = 6'h0c;  // First status pair of an END_OF_INTERRUPT_MESSAGE message.
  localparam logic [5:0] EOI_SECOND_CYC = 6'h0d;  // Second status pair of an END_OF_INTERRUPT_MESSAGE message.
  localparam logic [5:0] SHORT_A_CYC    = 6'h13;  // First status pair, cycle 19.
  localparam logic [5:0] SECOND_CYC     = 6'h14;  // Second status pair, cycle 20.
  localparam logic [5:0] THIRD_CYC      = 6'h21;  // Third status pair, cycle 33.

  // Cycle numbers at which the arbitration identifier is updated.
  localparam logic [5:0] EOI_UPD_CYC = 6'h0d;  // Cycle 13.
  localparam logic [5:0] UPD_CYC     = 6'h14;  // Cycle 20.

  // Counter value loaded in the cycle after the first message cycle.
  localparam logic [5:0] CYC_SECOND = 6'h02;
  localparam logic [5:0] CYC_RST    = 6'h00;  // Reset value of counters and cycle fields.

  // Status pair codes as sampled on bit 1 and bit 0 of the bus.
  localparam logic [1:0] PAIR_00 = 2'h0;  // Checksum good, or nothing driven.
  localparam logic [1:0] PAIR_01 = 2'h1;
  localparam logic [1:0] PAIR_10 = 2'h2;  // Accept, focus, or end and retry.
  localparam logic [1:0] PAIR_11 = 2'h3;  // Checksum error, retry, or do lowest.
  localparam logic [1:0] PAIR_RST = 2'h0;  // Reset value of captured pairs.

  // Message class, derived from the delivery mode by the receive path.
  typedef enum logic [1:0] {
    KIND_EOI    = 2'h0,  // End-of-interrupt message.
    KIND_SHORT  = 2'h1,  // Fixed, NMI, system management, init, external, start-up.
    KIND_LOWEST = 2'h2   // Lowest-priority delivery.
  } sibdec_kind_t;

  // Decoder sequencer states, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,  // Waiting for the first cycle of a message.
    ST_RUN  = 3'h2,  // Counting message cycles and capturing status.
    ST_SPARE = 3'h4  // Never entered; recovers to idle.
  } sibdec_state_t;

  // Outcome of one decoded message.
  typedef struct packed {
    logic       upd;    // Arbitration identifier is updated.
    logic [5:0] cyc;    // Cycle of the update, zero when none.
    logic [5:0] len;    // Final message length.
    logic       retry;  // Sender must resend.
  } sibdec_result_t;

endpackage : sibdec_pkg

// File: sibdec_pair_if.sv
// Carrier for the synchronised status pair between the decoder modules.
`timescale 1ns/1ps
`default_nettype none
interface sibdec_pair_if;
  logic [1:0] pair;  // Bus bit 1 and bit 0 after synchronisation.
  modport src (output pair);
  modport dst (input pair);
endinterface : sibdec_pair_if
`default_nettype wire

// File: sibdec_sync.sv
// Two-stage synchroniser for the two serial bus pins.
`timescale 1ns/1ps
`default_nettype none
module sibdec_sync (
  input  wire logic   mclk,      // System clock.
  input  wire logic   srst,      // Synchronous reset, active high.
  input  wire logic [1:0] bus_pins,  // Raw bus pins from outside the clock domain.
  sibdec_pair_if.src  out        // Synchronised pair.
);
  import sibdec_pkg::*;

  logic [1:0] meta_q;  // First stage; read only by the second stage.
  logic [1:0] meta_d;
  logic [1:0] pair_q;  // Second stage, safe to decode.
  logic [1:0] pair_d;

  // Next values of both stages; the pins are asynchronous to mclk.
  always_comb begin
    meta_d = bus_pins;
    pair_d = meta_q;
    if (srst) begin
      meta_d = PAIR_RST;
      pair_d = PAIR_RST;
    end
  end

  // Register both stages.
  always_ff @(posedge mclk) begin
    meta_q <= meta_d;
    pair_q <= pair_d;
  end

  assign out.pair = pair_q;

endmodule : sibdec_sync
`default_nettype wire

// File: sibdec_top.sv
// Status cycle decoder for messages on the shared two-bit serial interrupt bus.
`timescale 1ns/1ps
`default_nettype none
module sibdec_top (
  input  wire logic                    mclk,            // System clock, 50 MHz.
  input  wire logic                    srst,            // Synchronous reset, active high.
  input  wire logic [1:0]              bus_pins,        // Bus bit 1 and bit 0 as received.
  input  wire logic                    msg_start,       // Pulse in the first cycle of a message.
  input  wire sibdec_pkg::sibdec_kind_t msg_kind,       // Class of the starting message.
  input  wire logic                    checksum_bad,    // Own checksum disagrees with the bus.
  output logic                         busy,            // A message is being followed.
  output logic                         msg_done,        // Pulse when a result is posted.
  output logic                         arb_update,      // Arbitration identifier is updated.
  output logic [5:0]                   arb_cycle,       // Cycle of that update, zero when none.
  output logic [5:0]                   msg_length,      // Final message length in cycles.
  output logic                         retry,           // Sender must resend the message.
  output logic                         retry_request,   // Pulse to transmit control to resend.
  output logic                         no_focus_agent,  // Lowest mode ran without a focus.
  output logic [1:0]                   status_drive,    // Value driven onto the bus pins.
  output logic                         status_oe        // High while the pins are driven.
);
  import sibdec_pkg::*;

  sibdec_pair_if pair_if ();  // Synchronised status pair.

  // Pins come from other agents and are synchronised before any decoding.
  sibdec_sync u_sync (
    .mclk     (mclk),
    .srst     (srst),
    .bus_pins (bus_pins),
    .out      (pair_if.src)
  );

  // Cycle of the first status pair for a class.
  function automatic logic [5:0] a_cyc_of(input sibdec_kind_t k);
    a_cyc_of = (k == KIND_EOI) ? EOI_A_CYC : SHORT_A_CYC;
  endfunction : a_cyc_of

  // Cycle of the second status pair for a class.
  function automatic logic [5:0] second_cyc_of(input sibdec_kind_t k);
    second_cyc_of = (k == KIND_EOI) ? EOI_SECOND_CYC : SECOND_CYC;
  endfunction : second_cyc_of

  // Last cycle of the message; a lowest-mode error in the first pair cuts it to 21.
  function automatic logic [5:0] end_cyc_of(input sibdec_kind_t k, input logic [1:0] a);
    if (k == KIND_EOI) begin
      end_cyc_of = EOI_LEN;
    end else if (k == KIND_LOWEST && (a == PAIR_00 || a == PAIR_10)) begin
      end_cyc_of = LOWEST_LEN;
    end else begin
      end_cyc_of = SHORT_LEN;
    end
  endfunction : end_cyc_of

  // Interpret the captured pairs for the message class.
  function automatic sibdec_result_t decode(input sibdec_kind_t k, input logic [1:0] a,
                                            input logic [1:0] second, input logic [1:0] third);
    sibdec_result_t r;
    r.upd   = 1'b0;
    r.cyc   = CYC_RST;
    r.len   = end_cyc_of(k, a);
    r.retry = 1'b1;
    if (k == KIND_LOWEST) begin
      if (a == PAIR_10) begin
        r.upd   = 1'b1;
        r.retry = 1'b0;
      end else if (a == PAIR_00) begin
        if (second == PAIR_11) begin
          r.upd   = 1'b1;
          r.retry = (third != PAIR_10);
        end else if (second == PAIR_10) begin
          r.upd = 1'b1;
        end
        // A second pair of 0X leaves no update and a retry.
      end
      // First pair 11 or 01 leaves no update and a retry.
    end else if (a == PAIR_00) begin
      if (second == PAIR_10 || second == PAIR_11) begin
        r.upd   = 1'b1;
        r.retry = (second == PAIR_11);
      end
    end
    // Any other first pair is a checksum or plain error: defaults stand.
    if (r.upd) begin
      r.cyc = (k == KIND_EOI) ? EOI_UPD_CYC : UPD_CYC;
    end
    decode = r;
  endfunction : decode

  sibdec_state_t  state_q, state_d;  // Sequencer state.
  sibdec_kind_t   kind_q, kind_d;    // Class latched at message start.
  logic [5:0]     cyc_q, cyc_d;      // Number of the current bus cycle.
  logic [1:0]     a_q, a_d;          // First status pair.
  logic [1:0]     second_q, second_d;  // Second status pair.
  logic [1:0]     third_q, third_d;    // Third status pair.
  sibdec_result_t res_q, res_d;      // Posted outcome, held until the next one.
  logic           done_q, done_d;    // Outcome posted last cycle.
  logic           nof_q, nof_d;      // Lowest mode without a focus.
  logic           oe_q, oe_d;        // Checksum error drive enable.

  // Next-state logic; a start while busy is ignored, since the bus carries one message.
  always_comb begin
    state_d = state_q;
    kind_d  = kind_q;
    cyc_d   = cyc_q;
    a_d     = a_q;
    second_d = second_q;
    third_d  = third_q;
    res_d   = res_q;
    nof_d   = nof_q;
    done_d  = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (msg_start) begin
          state_d = ST_RUN;
          kind_d  = msg_kind;
          cyc_d   = CYC_SECOND;
          a_d     = PAIR_RST;
          second_d = PAIR_RST;
          third_d  = PAIR_RST;
        end
      end
      ST_RUN: begin
        cyc_d = cyc_q + 6'h01;
        // Every agent samples the first pair in its status cycle.
        if (cyc_q == a_cyc_of(kind_q)) begin
          a_d = pair_if.pair;
        end
        if (cyc_q == second_cyc_of(kind_q)) begin
          second_d = pair_if.pair;
        end
        if (kind_q == KIND_LOWEST && cyc_q == THIRD_CYC) begin
          third_d = pair_if.pair;
        end
        // Post the outcome once the last status is in hand.
        if (cyc_q == end_cyc_of(kind_q, a_q)) begin
          res_d   = decode(kind_q, a_q, second_q, third_q);
          nof_d   = (kind_q == KIND_LOWEST) && (a_q == PAIR_00);
          done_d  = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;  // Illegal code recovers to idle.
      end
    endcase
    // Drive 11 during the first status cycle when our checksum disagrees.
    oe_d = (state_d == ST_RUN) && (cyc_d == a_cyc_of(kind_d)) && checksum_bad;
    if (srst) begin
      state_d = ST_IDLE;
      kind_d  = KIND_EOI;
      cyc_d   = CYC_RST;
      a_d     = PAIR_RST;
      second_d = PAIR_RST;
      third_d  = PAIR_RST;
      res_d   = '0;
      nof_d   = 1'b0;
      done_d  = 1'b0;
      oe_d    = 1'b0;
    end
  end

  // Register all decoder state.
  always_ff @(posedge mclk) begin
    state_q <= state_d;
    kind_q  <= kind_d;
    cyc_q   <= cyc_d;
    a_q     <= a_d;
    second_q <= second_d;
    third_q  <= third_d;
    res_q   <= res_d;
    done_q  <= done_d;
    nof_q   <= nof_d;
    oe_q    <= oe_d;
  end

  assign busy           = (state_q == ST_RUN);
  assign msg_done       = done_q;
  assign arb_update     = res_q.upd;
  assign arb_cycle      = res_q.cyc;
  assign msg_length     = res_q.len;
  assign retry          = res_q.retry;
  assign retry_request  = done_q & res_q.retry;
  assign no_focus_agent = nof_q;
  assign status_drive   = oe_q ? PAIR_11 : PAIR_00;
  assign status_oe      = oe_q;

  // Any error in the first pair forbids the update and forces a resend.
  a_first_err_retry: assert property (@(posedge mclk) disable iff (srst)
    done_q && (a_q == PAIR_11 || a_q == PAIR_01 || (a_q == PAIR_10 && kind_q != KIND_LOWEST))
    |-> !res_q.upd && res_q.retry && res_q.cyc == 6'h00)
    else $error("first status error not retried");

  // A focus in lowest mode accepts with the cycle 20 update.
  a_focus_accept: assert property (@(posedge mclk) disable iff (srst)
    done_q && kind_q == KIND_LOWEST && a_q == PAIR_10
    |-> res_q.upd && res_q.cyc == 6'h14 && !res_q.retry)
    else $error("focus outcome wrong");

  // An END_OF_INTERRUPT_MESSAGE message posts its 14-cycle result fourteen clocks after it starts.
  a_eoi_timing: assert property (@(posedge mclk) disable iff (srst)
    state_q == ST_IDLE && msg_start && msg_kind == KIND_EOI
    |-> ##14 done_q && res_q.len == 6'h0e && (res_q.upd -> res_q.cyc == 6'h0d))
    else $error("END_OF_INTERRUPT_MESSAGE timing wrong");

  // A short message posts its 21-cycle result; retry follows a second pair of 11.
  a_short_timing: assert property (@(posedge mclk) disable iff (srst)
    state_q == ST_IDLE && msg_start && msg_kind == KIND_SHORT
    |-> ##21 done_q && res_q.len == 6'h15 && (second_q == PAIR_11 && a_q == PAIR_00
        -> res_q.upd && res_q.retry && res_q.cyc == 6'h14))
    else $error("short message outcome wrong");

  // Arbitration without a focus runs 34 cycles and updates at cycle 20.
  a_lowest_arbit: assert property (@(posedge mclk) disable iff (srst)
    done_q && kind_q == KIND_LOWEST && a_q == PAIR_00 && second_q == PAIR_11
    |-> res_q.upd && res_q.cyc == 6'h14 && res_q.len == 6'h22 && nof_q)
    else $error("lowest arbitration outcome wrong");

  // The third pair alone decides the retry of an arbitrated message.
  a_third_status: assert property (@(posedge mclk) disable iff (srst)
    done_q && kind_q == KIND_LOWEST && a_q == PAIR_00 && second_q == PAIR_11
    |-> res_q.retry == (third_q != PAIR_10))
    else $error("third status decode wrong");

  // End and retry still updates and runs the full length.
  a_end_retry: assert property (@(posedge mclk) disable iff (srst)
    done_q && kind_q == KIND_LOWEST && a_q == PAIR_00 && second_q == PAIR_10
    |-> res_q.upd && res_q.retry && res_q.len == 6'h22)
    else $error("end and retry outcome wrong");

  // A second pair of 0X without a focus is an error with no update.
  a_lowest_err: assert property (@(posedge mclk) disable iff (srst)
    done_q && kind_q == KIND_LOWEST && a_q == PAIR_00 && !second_q[1]
    |-> !res_q.upd && res_q.retry)
    else $error("lowest second status error wrong");

  // The error drive is 11 and lasts one cycle, in the first status cycle only.
  a_chk_drive: assert property (@(posedge mclk) disable iff (srst)
    status_oe |-> status_drive == 2'h3 && cyc_q == a_cyc_of(kind_q) && busy
    ##1 !status_oe)
    else $error("checksum error drive misplaced");

  // A resend request appears exactly once, at the posting of a retry outcome.
  a_retry_req: assert property (@(posedge mclk) disable iff (srst)
    retry_request |-> $past(busy) && retry ##1 !retry_request)
    else $error("retry request not tied to outcome");

endmodule : sibdec_top
`default_nettype wire

// File: sibdec_bus_model.sv
// Behavioural model of the other agents that share the serial interrupt bus.
`timescale 1ns/1ps
`default_nettype none
module sibdec_bus_model (
  input  wire logic                     mclk,       // System clock.
  input  wire logic                     srst,       // Synchronous reset, active high.
  input  wire logic                     go,         // Pulse that launches one message.
  input  wire sibdec_pkg::sibdec_kind_t kind_in,    // Class of the message to send.
  input  wire logic [1:0]               st_a,       // First status pair the agents drive.
  input  wire logic [1:0]               st_second,  // Second status pair.
  input  wire logic [1:0]               st_third,   // Third status pair.
  output logic [1:0]                    bus_pins,   // Wires as the decoder receives them.
  output logic                          msg_start,  // Cycle one in the synchronised stream.
  output sibdec_pkg::sibdec_kind_t      msg_kind,   // Class held for the whole message.
  output logic                          active      // A message is on the wire.
);
  import sibdec_pkg::*;
  logic [5:0]   pc_q;    // Pin cycle index, zero when idle.
  logic [1:0]   fr_q;    // Moving pattern, so a data or idle cycle never looks steady.
  sibdec_kind_t kind_q;  // Class latched at launch.

  // Pins lead the decoder by two clocks; one run lasts 40 pin cycles, longer than the longest frame plus that lead.
  always_ff @(posedge mclk) begin
    fr_q <= srst ? 2'h0 : fr_q + 2'h1;  // Reset so the filler never carries unknowns.
    if (srst) begin
      pc_q   <= 6'h00;
      kind_q <= KIND_EOI;
    end else if (go) begin
      pc_q   <= 6'h01;
      kind_q <= kind_in;
    end else if (pc_q == 6'h28) begin
      pc_q <= 6'h00;
    end else if (pc_q != 6'h00) begin
      pc_q <= pc_q + 6'h01;
    end
  end

  // Status pairs appear in their own cycles; everything else is filler that keeps moving.
  always_comb begin
    bus_pins = fr_q;
    if (kind_q == KIND_EOI) begin
      if (pc_q == EOI_A_CYC) bus_pins = st_a;
      if (pc_q == EOI_SECOND_CYC) bus_pins = st_second;
    end else begin
      if (pc_q == SHORT_A_CYC) bus_pins = st_a;
      if (pc_q == SECOND_CYC) bus_pins = st_second;
      if (pc_q == THIRD_CYC) bus_pins = st_third;
    end
  end

  assign msg_start = (pc_q == 6'h03);
  assign msg_kind  = kind_q;
  assign active    = (pc_q != 6'h00);
endmodule : sibdec_bus_model
`default_nettype wire

// File: serial_intr_bus_status_decoder_bench.sv
// Self-checking testbench for the serial interrupt bus status decoder.
`timescale 1ns/1ps
`default_nettype none
module serial_intr_bus_status_decoder_bench;
  import sibdec_pkg::*;
  logic         mclk, srst, go, cs_bad;            // Bench-driven controls.
  sibdec_kind_t kind, m_kind;                      // Requested and presented class.
  logic [1:0]   pa, pa1, pa2, pins, st_drive;      // Status pairs and wires.
  logic         m_start, m_act, busy, done, upd;   // Handshake and results.
  logic         rty, rty_req, nofoc, st_oe;        // Further results.
  logic [5:0]   acyc, mlen;                        // Update cycle and length.
  int           error_cnt, check_count;            // Mismatch and comparison counts.

  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    go = 1'b0;
    cs_bad = 1'b0;
    kind = KIND_EOI;
    pa = 2'h0;
    pa1 = 2'h0;
    pa2 = 2'h0;
  end
  always #10 mclk = ~mclk;

  sibdec_bus_model sibdec_bus_model_i (.mclk(mclk), .srst(srst), .go(go), .kind_in(kind),
    .st_a(pa), .st_second(pa1), .st_third(pa2), .bus_pins(pins), .msg_start(m_start),
    .msg_kind(m_kind), .active(m_act));
  sibdec_top sibdec_top_i (.mclk(mclk), .srst(srst), .bus_pins(pins), .msg_start(m_start),
    .msg_kind(m_kind), .checksum_bad(cs_bad), .busy(busy), .msg_done(done),
    .arb_update(upd), .arb_cycle(acyc), .msg_length(mlen), .retry(rty),
    .retry_request(rty_req), .no_focus_agent(nofoc), .status_drive(st_drive),
    .status_oe(st_oe));

  // Compares with case equality so an unknown never passes.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // Sends one message and judges timing, drive and results; a lost answer ends the run.
  task automatic run_msg(input sibdec_kind_t k, input logic [1:0] a, input logic [1:0] s2,
                         input logic [1:0] s3, input logic cs, input logic eu,
                         input logic [5:0] ec, input logic [5:0] el, input logic er);
    int n;
    int len;
    int oe_n;
    bit started;
    len = 0;
    oe_n = 0;
    started = 1'b0;
    @(posedge mclk);
    go <= 1'b1;
    kind <= k;
    pa <= a;
    pa1 <= s2;
    pa2 <= s3;
    cs_bad <= cs;
    @(posedge mclk);
    go <= 1'b0;
    for (n = 0; n < 80; n++) begin
      @(posedge mclk);
      #1;
      if (started) len++;
      if (st_oe === 1'b1) begin
        oe_n++;
        check("status_drive", st_drive, PAIR_11);
      end
      if (started && done === 1'b1) break;
      if (m_start === 1'b1) started = 1'b1;
    end
    if (n == 80) begin
      check("msg_done", 1'b0, 1'b1);
      final_report();
    end
    check("done_delay", len, el);
    check("arb_update", upd, eu);
    check("arb_cycle", acyc, ec);
    check("msg_length", mlen, el);
    check("retry", rty, er);
    check("retry_request", rty_req, er);
    check("no_focus", nofoc, (k == KIND_LOWEST && a == PAIR_00));
    check("busy", busy, 1'b0);
    check("drive_count", oe_n, cs);
    cs_bad <= 1'b0;
    // Sample one nanosecond after each edge so the model has settled.
    for (n = 0; n < 60 && m_act === 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    check("model_idle", m_act, 1'b0);
    if (m_act !== 1'b0) begin
      final_report();
    end
  endtask : run_msg

  // Reset in mid-message clears every output; the next message then decodes normally.
  task automatic t_reset();
    @(posedge mclk);
    go <= 1'b1;
    kind <= KIND_LOWEST;
    pa <= PAIR_00;
    pa1 <= PAIR_11;
    pa2 <= PAIR_10;
    cs_bad <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (24) @(posedge mclk);
    srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    #1;
    check("reset_results", {busy, done, upd, acyc, mlen, rty, rty_req, nofoc}, 32'h0);
    check("reset_drive", {st_oe, st_drive}, 32'h0);
    run_msg(KIND_SHORT, 2'h0, 2'h2, 2'h0, 0, 1, UPD_CYC, SHORT_LEN, 0);
  endtask : t_reset

  // Every end-of-interrupt outcome, including all three faulty first pairs.
  task automatic t_eoi();
    run_msg(KIND_EOI, 2'h0, 2'h2, 2'h3, 0, 1, EOI_UPD_CYC, EOI_LEN, 0);
    run_msg(KIND_EOI, 2'h0, 2'h3, 2'h0, 0, 1, EOI_UPD_CYC, EOI_LEN, 1);
    run_msg(KIND_EOI, 2'h0, 2'h1, 2'h2, 0, 0, CYC_RST, EOI_LEN, 1);
    run_msg(KIND_EOI, 2'h3, 2'h2, 2'h2, 0, 0, CYC_RST, EOI_LEN, 1);
    run_msg(KIND_EOI, 2'h2, 2'h2, 2'h2, 0, 0, CYC_RST, EOI_LEN, 1);
    run_msg(KIND_EOI, 2'h1, 2'h2, 2'h2, 0, 0, CYC_RST, EOI_LEN, 1);
  endtask : t_eoi

  // Short deliveries; the third pair is set misleadingly since it must be ignored.
  task automatic t_short();
    run_msg(KIND_SHORT, 2'h0, 2'h2, 2'h3, 0, 1, UPD_CYC, SHORT_LEN, 0);
    run_msg(KIND_SHORT, 2'h0, 2'h3, 2'h2, 0, 1, UPD_CYC, SHORT_LEN, 1);
    run_msg(KIND_SHORT, 2'h0, 2'h0, 2'h2, 0, 0, CYC_RST, SHORT_LEN, 1);
    run_msg(KIND_SHORT, 2'h2, 2'h2, 2'h2, 0, 0, CYC_RST, SHORT_LEN, 1);
    run_msg(KIND_SHORT, 2'h1, 2'h2, 2'h2, 0, 0, CYC_RST, SHORT_LEN, 1);
  endtask : t_short

  // Lowest-priority paths, with and without a focus agent.
  task automatic t_lowest();
    run_msg(KIND_LOWEST, 2'h2, 2'h0, 2'h3, 0, 1, UPD_CYC, LOWEST_LEN, 0);
    run_msg(KIND_LOWEST, 2'h0, 2'h3, 2'h2, 0, 1, UPD_CYC, LOWEST_LEN, 0);
    run_msg(KIND_LOWEST, 2'h0, 2'h3, 2'h3, 0, 1, UPD_CYC, LOWEST_LEN, 1);
    run_msg(KIND_LOWEST, 2'h0, 2'h3, 2'h0, 0, 1, UPD_CYC, LOWEST_LEN, 1);
    run_msg(KIND_LOWEST, 2'h0, 2'h3, 2'h1, 0, 1, UPD_CYC, LOWEST_LEN, 1);
    run_msg(KIND_LOWEST, 2'h0, 2'h2, 2'h2, 0, 1, UPD_CYC, LOWEST_LEN, 1);
    run_msg(KIND_LOWEST, 2'h0, 2'h0, 2'h2, 0, 0, CYC_RST, LOWEST_LEN, 1);
    run_msg(KIND_LOWEST, 2'h0, 2'h1, 2'h2, 0, 0, CYC_RST, LOWEST_LEN, 1);
    run_msg(KIND_LOWEST, 2'h3, 2'h2, 2'h2, 0, 0, CYC_RST, SHORT_LEN, 1);
    run_msg(KIND_LOWEST, 2'h1, 2'h2, 2'h2, 0, 0, CYC_RST, SHORT_LEN, 1);
  endtask : t_lowest

  // Own checksum disagrees: one cycle of drive, and the message is dropped.
  task automatic t_cksum();
    run_msg(KIND_EOI, 2'h3, 2'h2, 2'h2, 1, 0, CYC_RST, EOI_LEN, 1);
    run_msg(KIND_SHORT, 2'h3, 2'h2, 2'h2, 1, 0, CYC_RST, SHORT_LEN, 1);
    run_msg(KIND_LOWEST, 2'h3, 2'h3, 2'h2, 1, 0, CYC_RST, SHORT_LEN, 1);
  endtask : t_cksum

  // Reset for three clocks, then every scenario in turn.
  initial begin
    error_cnt = 0;
    check_count = 0;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    t_eoi();
    t_short();
    t_lowest();
    t_cksum();
    t_reset();
    final_report();
  end
endmodule : serial_intr_bus_status_decoder_bench
`default_nettype wire
